// ---- src/cmps_top.sv ----
// Comparator control: output shaping, timer sync, edge interrupt, hysteresis drive.
// Assumes a plain register port and a timer clock level sampled on i_clk.
//
// The implementer's own choices: the address map and the strobed register port.

// Notes on behaviour
// - The hysteresis select bit drives the hysteresis enable to the analog core.
// - The comparator output is offered as a gate source to the gateable timer.
// - With sync select set, the output is captured on each timer clock falling edge.
// - With a prescaler the capture uses the prescaled timer clock.
// - Capture changes only on the falling edge while the timer counts on the rising edge.
// - Each comparator has its own rising and falling edge detectors.
// - The flag sets on an enabled rising or an enabled falling edge.
// - The flag never clears in hardware, only by a software write.
// - An edge in the same cycle as a software clear leaves the flag set.
// - Toggling polarity or on/off counts as an output change; while off, polarity has no effect.
module cmps_top (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Analog core
  input  wire logic       i_core_result,
  output logic            o_hysteresis_enable,
  output logic            o_speed_power_select,
  output logic            o_comparator_on,
  // Gateable timer
  input  wire logic       i_tmr_prescaled_clk,
  output logic            o_timer_gate,
  // Interrupt
  output logic            o_irq
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] comparator_control_a;
  logic [7:0] comparator_control_b;
  logic       comparator_irq_flag;
  logic       comparator_irq_enable;
  logic [7:0] interrupt_control_reg;
  logic [7:0] next_rdata;

  wire wr_a    = i_wr && (i_addr == cmps_pkg::CMPS_ADDR_CTRL_A);
  wire wr_b    = i_wr && (i_addr == cmps_pkg::CMPS_ADDR_CTRL_B);
  wire wr_flag = i_wr && (i_addr == cmps_pkg::CMPS_ADDR_FLAG);
  wire wr_ien  = i_wr && (i_addr == cmps_pkg::CMPS_ADDR_IEN);
  wire wr_intc = i_wr && (i_addr == cmps_pkg::CMPS_ADDR_INTC);

  wire comparator_on   = comparator_control_a[cmps_pkg::CMPS_A_ON];
  wire output_polarity = comparator_control_a[cmps_pkg::CMPS_A_POL];
  wire sync_select     = comparator_control_a[cmps_pkg::CMPS_A_SYNC];
  wire hysteresis_sel  = comparator_control_a[cmps_pkg::CMPS_A_HYS];
  wire rising_edge_irq_enable  = comparator_control_b[cmps_pkg::CMPS_B_RISE];
  wire falling_edge_irq_enable = comparator_control_b[cmps_pkg::CMPS_B_FALL];
  wire global_irq_enable     = interrupt_control_reg[cmps_pkg::CMPS_I_GIE];
  wire peripheral_irq_enable = interrupt_control_reg[cmps_pkg::CMPS_I_PERIPHERAL_IRQ_ENABLE];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      comparator_control_a  <= cmps_pkg::CMPS_RST_VAL;
      comparator_control_b  <= cmps_pkg::CMPS_RST_VAL;
      comparator_irq_enable <= 1'b0;
      interrupt_control_reg <= cmps_pkg::CMPS_RST_VAL;
    end else begin
      if (wr_a) comparator_control_a <= i_wdata;
      if (wr_b) comparator_control_b <= i_wdata;
      if (wr_ien) comparator_irq_enable <= i_wdata[cmps_pkg::CMPS_E_IE];
      if (wr_intc) interrupt_control_reg <= i_wdata;
    end
  end

  // ****************************************
  // Output shaping, sync and edges
  // ****************************************
  // Polarity and on/off act after the core, so changing them moves the level
  wire cmp_raw = comparator_on & (i_core_result ^ output_polarity);

  cmps_if link ();
  cmps_sync u_sync (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_sync_select (sync_select),
    .i_tmr_clk     (i_tmr_prescaled_clk),
    .i_cmp_out     (cmp_raw),
    .o_out         (link.out_level)
  );
  cmps_edge u_edge (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .bus     (link.det)
  );

  wire edge_hit = (link.rise && rising_edge_irq_enable) ||
                  (link.fall && falling_edge_irq_enable);

  // Set takes priority over a software clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      comparator_irq_flag <= 1'b0;
    end else if (edge_hit) begin
      comparator_irq_flag <= 1'b1;
    end else if (wr_flag) begin
      comparator_irq_flag <= i_wdata[cmps_pkg::CMPS_F_IF];
    end
  end

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    case (i_addr)
      cmps_pkg::CMPS_ADDR_CTRL_A: next_rdata = comparator_control_a;
      cmps_pkg::CMPS_ADDR_CTRL_B: next_rdata = comparator_control_b;
      cmps_pkg::CMPS_ADDR_FLAG:   next_rdata[cmps_pkg::CMPS_F_IF] = comparator_irq_flag;
      cmps_pkg::CMPS_ADDR_IEN:    next_rdata[cmps_pkg::CMPS_E_IE] = comparator_irq_enable;
      cmps_pkg::CMPS_ADDR_INTC:   next_rdata = interrupt_control_reg;
      cmps_pkg::CMPS_ADDR_STATUS: begin
        next_rdata[cmps_pkg::CMPS_S_OUT] = link.out_level;
        next_rdata[cmps_pkg::CMPS_S_RAW] = cmp_raw;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_hysteresis_enable  = hysteresis_sel;
  assign o_speed_power_select = comparator_control_a[cmps_pkg::CMPS_A_SP];
  assign o_comparator_on      = comparator_on;
  assign o_timer_gate         = link.out_level;
  // The flag and all three enables (comparator, peripheral, global) must be set for the request to leave
  assign o_irq = comparator_irq_flag && comparator_irq_enable &&
                 peripheral_irq_enable && global_irq_enable;

endmodule

// ---- include/cmps_pkg.sv ----
// Shared constants for the comparator sync and interrupt block.
// Assumes a single 200 MHz system clock; the timer clock arrives as a synchronous level.
package cmps_pkg;

  // ****************************************
  // Register map (word offsets on the plain port)
  // ****************************************
  localparam logic [3:0] CMPS_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] CMPS_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] CMPS_ADDR_FLAG   = 4'h2;
  localparam logic [3:0] CMPS_ADDR_IEN    = 4'h3;
  localparam logic [3:0] CMPS_ADDR_INTC   = 4'h4;
  localparam logic [3:0] CMPS_ADDR_STATUS = 4'h5;

  // ****************************************
  // Field positions
  // ****************************************
  // comparator_control_a
  localparam int CMPS_A_ON    = 7;
  localparam int CMPS_A_POL   = 4;
  localparam int CMPS_A_SP    = 2;
  localparam int CMPS_A_HYS   = 1;
  localparam int CMPS_A_SYNC  = 0;
  // comparator_control_b
  localparam int CMPS_B_RISE  = 7;
  localparam int CMPS_B_FALL  = 6;
  // flag, enable, interrupt control
  localparam int CMPS_F_IF    = 0;
  localparam int CMPS_E_IE    = 0;
  localparam int CMPS_I_GIE   = 7;
  localparam int CMPS_I_PERIPHERAL_IRQ_ENABLE  = 6;
  // status
  localparam int CMPS_S_OUT   = 0;
  localparam int CMPS_S_RAW   = 1;

  localparam logic [7:0] CMPS_RST_VAL = 8'h00;

  typedef enum logic [1:0] {
    CMPS_TCK_LOW  = 2'b00,
    CMPS_TCK_HIGH = 2'b01
  } cmps_tck_t;

endpackage

// ---- include/cmps_if.sv ----
// Carries the comparator output level between the top and its helpers.
// Assumes all users run on the system clock.
interface cmps_if;
  logic out_level;
  logic rise;
  logic fall;
  modport src (output out_level);
  modport det (input out_level, output rise, output fall);
  modport use_ (input rise, input fall);
endinterface

// ---- src/cmps_sync.sv ----
// Latches the comparator output on the falling edge of the prescaled timer clock.
// Assumes the prescaled timer clock is a synchronous level on i_clk.
module cmps_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Controls
  input  wire logic i_sync_select,
  input  wire logic i_tmr_clk,
  input  wire logic i_cmp_out,
  // Result
  output logic      o_out
);

  cmps_pkg::cmps_tck_t tck_state;
  logic                held;
  wire                 tck_fall = (tck_state == cmps_pkg::CMPS_TCK_HIGH) && !i_tmr_clk;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tck_state <= cmps_pkg::CMPS_TCK_LOW;
    end else begin
      tck_state <= i_tmr_clk ? cmps_pkg::CMPS_TCK_HIGH : cmps_pkg::CMPS_TCK_LOW;
    end
  end

  // Only the falling edge updates, so a counter on the rising edge never races it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held <= 1'b0;
    end else if (tck_fall) begin
      held <= i_cmp_out;
    end
  end

  assign o_out = i_sync_select ? held : i_cmp_out;

endmodule

// ---- src/cmps_edge.sv ----
// Rising and falling edge detector on the comparator output level.
// Assumes the level is already on i_clk.
module cmps_edge (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Level in, pulses out
  cmps_if.det       bus
);

  logic prev;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev <= 1'b0;
    end else begin
      prev <= bus.out_level;
    end
  end

  assign bus.rise = bus.out_level && !prev;
  assign bus.fall = !bus.out_level && prev;

endmodule

// ---- verification/cmps_top_sva.sv ----
// Port checker for cmps_top, bound in after the module.
// Assumes control writes land one cycle after the strobe.
module cmps_chk (
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_core_result,
  input wire logic       o_hysteresis_enable,
  input wire logic       o_speed_power_select,
  input wire logic       o_comparator_on,
  input wire logic       i_tmr_prescaled_clk,
  input wire logic       o_timer_gate,
  input wire logic       o_irq
);
  // Mirror of polarity (bit 1) and sync select (bit 0)
  logic [1:0] mir;
  wire        wr_a = i_wr && i_addr == 4'h0;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mir <= 2'h0;
    end else if (wr_a) begin
      mir <= {i_wdata[4], i_wdata[0]};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_hys_follow: assert property (wr_a |=> o_hysteresis_enable == $past(i_wdata[1]))
    else $error("hysteresis enable wrong");
  a_speed_follow: assert property (wr_a |=> o_speed_power_select == $past(i_wdata[2]))
    else $error("speed select wrong");
  a_on_follow: assert property (wr_a |=> o_comparator_on == $past(i_wdata[7]))
    else $error("comparator on wrong");
  a_flag_sticky: assert property (o_irq && !i_wr |=> o_irq)
    else $error("interrupt dropped without a write");
  a_rd_unmapped: assert property (i_rd && i_addr > 4'h5 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_gate_sync: assert property (mir[0] && $past(mir[0]) && $changed(o_timer_gate)
    |-> $past(i_tmr_prescaled_clk, 2) && !$past(i_tmr_prescaled_clk))
    else $error("synced gate moved off the falling edge");
  a_gate_direct: assert property (!mir[0]
    |-> o_timer_gate == (o_comparator_on & (i_core_result ^ mir[1])))
    else $error("direct gate wrong");
endmodule

bind cmps_top cmps_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_core_result(i_core_result), .o_hysteresis_enable(o_hysteresis_enable),
  .o_speed_power_select(o_speed_power_select), .o_comparator_on(o_comparator_on),
  .i_tmr_prescaled_clk(i_tmr_prescaled_clk), .o_timer_gate(o_timer_gate), .o_irq(o_irq));

// ---- verification/cmps_tmr_model.sv ----
// Gateable timer stand-in: prescaled clock source and gated counter.
// Assumes the gate level comes from the comparator block on i_clk.
module cmps_tmr_model #(
  parameter int HALF = 4
) (
  // Clock, reset, gate
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_gate,
  // Prescaled clock and count
  output logic            o_tmr_clk,
  output logic      [7:0] o_count
);
  int div;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div       <= 0;
      o_tmr_clk <= 1'b0;
      o_count   <= 8'h00;
    end else if (div == HALF - 1) begin
      div       <= 0;
      o_tmr_clk <= !o_tmr_clk;
      // Counts only on the rising edge, away from the capture edge
      if (!o_tmr_clk && i_gate) o_count <= o_count + 8'h01;
    end else begin
      div <= div + 1;
    end
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the comparator control block.
// Assumes the timer stand-in makes the prescaled clock (8 system cycles).
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk;
  logic       i_rst_b;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_core_result;
  logic [7:0] o_rdata;
  logic       hys;
  logic       spd;
  logic       on;
  logic       tclk;
  logic       gate;
  logic       o_irq;
  logic [7:0] cnt;
  logic [7:0] v;
  int         error_cnt;
  int         comparisons;
  int         cycles;
  cmps_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_result(i_core_result),
    .o_hysteresis_enable(hys), .o_speed_power_select(spd), .o_comparator_on(on),
    .i_tmr_prescaled_clk(tclk), .o_timer_gate(gate), .o_irq(o_irq));
  cmps_tmr_model #(.HALF(4)) tmr (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_gate(gate),
    .o_tmr_clk(tclk), .o_count(cnt));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Strobes are driven just after an edge and dropped at the edge that takes them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    #1;
  endtask
  // Write whose sampling edge also sees a new core result level
  task automatic wr_core(input logic [3:0] a, input logic [7:0] d, input logic c);
    @(posedge i_clk);
    i_core_result <= c;
    i_addr        <= a;
    i_wdata       <= d;
    i_wr          <= 1'b1;
    @(posedge i_clk);
    i_wr          <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    for (int a = 0; a < 16; a += 3) begin
      rd(4'(a));
      check(v, 8'h00);
    end
    wr(4'h0, 8'h06);
    check({hys, spd}, 8'h03);
    wr(4'h0, 8'h00);
    check({hys, spd}, 8'h00);
  endtask
  task automatic t_irq();
    wr(4'h1, 8'hc0);
    wr(4'h3, 8'h01);
    wr(4'h4, 8'hc0);
    i_core_result <= 1'b1;
    wr(4'h0, 8'h80);
    cyc(2);
    check(o_irq, 1'b1);
    cyc(6);
    check(o_irq, 1'b1);
    wr(4'h2, 8'h00);
    cyc(1);
    check(o_irq, 1'b0);
    i_core_result <= 1'b0;
    cyc(3);
    check(o_irq, 1'b1);
    wr_core(4'h2, 8'h00, 1'b1);
    cyc(2);
    check(o_irq, 1'b1);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h80);
    i_core_result <= 1'b0;
    cyc(3);
    rd(4'h2);
    check({v[0], o_irq}, 8'h00);
    wr(4'h0, 8'h90);
    cyc(2);
    check(o_irq, 1'b1);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    cyc(3);
    check(o_irq, 1'b0);
  endtask
  task automatic t_sync();
    wr(4'h0, 8'h81);
    while (tclk) cyc(1);
    while (!tclk) cyc(1);
    i_core_result <= 1'b1;
    cyc(2);
    check(gate, 1'b0);
    while (tclk) cyc(1);
    cyc(2);
    check(gate, 1'b1);
    rd(4'h5);
    check(v, 8'h03);
    v = cnt;
    cyc(40);
    check(cnt - v, 8'h05);
    wr(4'h0, 8'h80);
    i_core_result <= 1'b0;
    cyc(1);
    check(gate, 1'b0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    i_rst_b       = 1'b0;
    i_addr        = 4'h0;
    i_wdata       = 8'h00;
    i_wr          = 1'b0;
    i_rd          = 1'b0;
    i_core_result = 1'b0;
    cyc(4);
    i_rst_b <= 1'b1;
    cyc(1);
    t_regs();
    t_irq();
    t_sync();
    print_verdict();
  end
endmodule
